// *** hw/tsru_pkg.sv ***
// Constants, register map and mode codes of the timer split and reload unit.
// Assumes one 250 MHz system clock and a byte-wide register port with 4-bit addresses.
//
// What this block does
// R01: Timer zero mode 3 splits into two bytes
// R02: Split low byte counts system or external clock
// R03: Split high byte: timer only, timer one controls
// R04: Timer one in split: no flag, overflow tick
// R05: Timer one runs in modes 0-2, stops in 3
// R06: Gate requires run and active gate input
// R07: Counter select picks prescaled clock or pin falls
// R08: Timer one modes: 13, 16, 8 reload, off
// R09: Timer zero mode 3 means two 8-bit counters
// R10: Timer three is 16 bits, split/capture select mode
// R11: Timer three clocks: system, /12, external /8
// R12: 16-bit wrap loads reload, sets high flag
// R13: Interrupt on overflow, low wrap when enabled
// R14: Split: two 8-bit counters with own reloads
// R15: Split: run gates high byte only
// R16: Split: per-half clock select, external select
// R17: Split: each half sets own flag, interrupts
// R18: Software clears timer three flags itself
// R19: 13-bit mode: 5-bit prescale carries into high
package tsru_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] TSRU_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] TSRU_ADDR_MODE = 4'h1;
  localparam logic [3:0] TSRU_ADDR_CLKSEL = 4'h2;
  localparam logic [3:0] TSRU_ADDR_GATEPOL = 4'h3;
  localparam logic [3:0] TSRU_ADDR_T0LO = 4'h4;
  localparam logic [3:0] TSRU_ADDR_T0HI = 4'h5;
  localparam logic [3:0] TSRU_ADDR_T1LO = 4'h6;
  localparam logic [3:0] TSRU_ADDR_T1HI = 4'h7;
  localparam logic [3:0] TSRU_ADDR_T3CTRL = 4'h8;
  localparam logic [3:0] TSRU_ADDR_T3LO = 4'h9;
  localparam logic [3:0] TSRU_ADDR_T3HI = 4'ha;
  localparam logic [3:0] TSRU_ADDR_T3RLLO = 4'hb;
  localparam logic [3:0] TSRU_ADDR_T3RLHI = 4'hc;
  localparam logic [3:0] TSRU_ADDR_IRQSTAT = 4'hd;
  localparam logic [3:0] TSRU_ADDR_IRQMASK = 4'he;

  // ****************************************
  // Field positions
  // ****************************************
  // timer_control
  localparam int TSRU_CTL_T0RUN = 0;
  localparam int TSRU_CTL_T1RUN = 1;
  localparam int TSRU_CTL_T0FLAG = 2;
  localparam int TSRU_CTL_T1FLAG = 3;
  // timer_mode_select
  localparam int TSRU_MOD_T0MODE = 0;
  localparam int TSRU_MOD_T0CSEL = 2;
  localparam int TSRU_MOD_T0GATE = 3;
  localparam int TSRU_MOD_T1MODE = 4;
  localparam int TSRU_MOD_T1CSEL = 6;
  localparam int TSRU_MOD_T1GATE = 7;
  // clock_select_control
  localparam int TSRU_CKS_T0PRE = 0;
  localparam int TSRU_CKS_T1PRE = 1;
  localparam int TSRU_CKS_T3LOW = 2;
  localparam int TSRU_CKS_T3HIGH = 3;
  // t_three_control
  localparam int TSRU_T3C_EXTCLK = 0;
  localparam int TSRU_T3C_CAPSRC = 1;
  localparam int TSRU_T3C_RUN = 2;
  localparam int TSRU_T3C_SPLIT = 3;
  localparam int TSRU_T3C_CAPEN = 4;
  localparam int TSRU_T3C_LOWIRQ = 5;
  localparam int TSRU_T3C_LOWOVF = 6;
  localparam int TSRU_T3C_HIGHOVF = 7;
  // interrupt status and mask
  localparam int TSRU_IRQ_T0 = 0;
  localparam int TSRU_IRQ_T1 = 1;
  localparam int TSRU_IRQ_T3HIGH = 2;
  localparam int TSRU_IRQ_T3LOW = 3;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] TSRU_RESET_BYTE = 8'h00;
  localparam logic [3:0] TSRU_RESET_IRQ = 4'h0;
  localparam int TSRU_SYS_DIV = 12;
  localparam int TSRU_EXT_DIV = 8;
  localparam logic [3:0] TSRU_SYS_DIV_LAST = 4'(TSRU_SYS_DIV - 1);
  localparam logic [2:0] TSRU_EXT_DIV_LAST = 3'(TSRU_EXT_DIV - 1);
  localparam int TSRU_PIN_COUNT = 5;

  typedef enum logic [1:0] {
    TSRU_MODE_13BIT = 2'b00,
    TSRU_MODE_16BIT = 2'b01,
    TSRU_MODE_8RELOAD = 2'b10,
    TSRU_MODE_SPLIT = 2'b11
  } tsru_mode_type;

endpackage

// *** hw/tsru_timer_unit.sv ***
// Timers zero, one and three with register port and interrupt logic.
// Assumes pins are asynchronous to clk_sys and the register master follows the one-cycle strobe protocol.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps

module tsru_timer_unit
  import tsru_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic count_pin_zero,
  input wire logic count_pin_one,
  input wire logic ext_gate_in_zero,
  input wire logic ext_gate_in_one,
  input wire logic extClockIn,
  output logic irq,
  output logic t1OverflowTick
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] timer_control;
  logic [7:0] timer_mode_select;
  logic [7:0] clock_select_control;
  logic [1:0] gatePolarity;
  logic [7:0] t_zero_low_byte;
  logic [7:0] t_zero_high_byte;
  logic [7:0] t_one_low_byte;
  logic [7:0] t_one_high_byte;
  logic [7:0] t_three_control;
  logic [7:0] t_three_low_byte;
  logic [7:0] t_three_high_byte;
  logic [7:0] t_three_reload_low;
  logic [7:0] t_three_reload_high;
  logic [3:0] irqStatus;
  logic [3:0] irqMask;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [TSRU_PIN_COUNT-1:0] pinRaw;
  logic [TSRU_PIN_COUNT-1:0] pinSync1;
  logic [TSRU_PIN_COUNT-1:0] pinSync2;
  logic [TSRU_PIN_COUNT-1:0] pinSync3;
  logic [TSRU_PIN_COUNT-1:0] pinStable;
  logic [TSRU_PIN_COUNT-1:0] pinFall;
  logic [TSRU_PIN_COUNT-1:0] pinRise;

  assign pinRaw = {extClockIn, count_pin_one, count_pin_zero, ext_gate_in_one, ext_gate_in_zero};

  // A change only counts once stages two and three agree, which filters single-cycle glitches
  for (genvar i = 0; i < TSRU_PIN_COUNT; i++)
  begin : g_pin
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
      begin
        pinSync1[i] <= 1'b0;
        pinSync2[i] <= 1'b0;
        pinSync3[i] <= 1'b0;
        pinStable[i] <= 1'b0;
      end
      else
      begin
        pinSync1[i] <= pinRaw[i];
        pinSync2[i] <= pinSync1[i];
        pinSync3[i] <= pinSync2[i];
        if (pinSync2[i] == pinSync3[i])
          pinStable[i] <= pinSync3[i];
      end
    end
    assign pinFall[i] = pinStable[i] & ~pinSync3[i] & ~pinSync2[i];
    assign pinRise[i] = ~pinStable[i] & pinSync3[i] & pinSync2[i];
  end

  wire gateActive0 = pinStable[0] == gatePolarity[0];
  wire gateActive1 = pinStable[1] == gatePolarity[1];

  // ****************************************
  // Prescalers
  // ****************************************
  logic [3:0] sysDivCount;
  logic [2:0] extDivCount;
  wire preTick12 = sysDivCount == TSRU_SYS_DIV_LAST; // [R11]
  wire extTick8 = pinRise[4] && extDivCount == TSRU_EXT_DIV_LAST; // [R11]

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sysDivCount <= 4'h0;
      extDivCount <= 3'h0;
    end
    else
    begin
      sysDivCount <= preTick12 ? 4'h0 : sysDivCount + 4'h1;
      if (pinRise[4])
        extDivCount <= extDivCount + 3'h1;
    end
  end

  // ****************************************
  // Register decode
  // ****************************************
  wire wrCtl = regWrite && regAddr == TSRU_ADDR_CONTROL;
  wire wrT0Lo = regWrite && regAddr == TSRU_ADDR_T0LO;
  wire wrT0Hi = regWrite && regAddr == TSRU_ADDR_T0HI;
  wire wrT1Lo = regWrite && regAddr == TSRU_ADDR_T1LO;
  wire wrT1Hi = regWrite && regAddr == TSRU_ADDR_T1HI;
  wire wrT3Ctl = regWrite && regAddr == TSRU_ADDR_T3CTRL;
  wire wrT3Lo = regWrite && regAddr == TSRU_ADDR_T3LO;
  wire wrT3Hi = regWrite && regAddr == TSRU_ADDR_T3HI;
  wire rdStatus = regRead && regAddr == TSRU_ADDR_IRQSTAT;

  // ****************************************
  // Timers zero and one
  // ****************************************
  // Returns {overflow, high, low} after one count in modes 0 to 2
  function automatic logic [16:0] tsru_step(input logic [7:0] lo, input logic [7:0] hi, input logic [1:0] mode);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (mode)
      TSRU_MODE_13BIT:
      begin
        r[4:0] = lo[4:0] + 5'h01; // [R19]
        if (lo[4:0] == 5'h1f)
        begin
          r[15:8] = hi + 8'h01;
          r[16] = hi == 8'hff;
        end
      end
      TSRU_MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
      TSRU_MODE_8RELOAD:
      begin
        if (lo == 8'hff)
          r = {1'b1, hi, hi};
        else
          r[7:0] = lo + 8'h01;
      end
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  wire [1:0] t0Mode = timer_mode_select[TSRU_MOD_T0MODE +: 2];
  wire [1:0] t1Mode = timer_mode_select[TSRU_MOD_T1MODE +: 2];
  wire t0Split = t0Mode == TSRU_MODE_SPLIT; // [R09]
  wire t1Off = t1Mode == TSRU_MODE_SPLIT; // [R08]
  wire t0Run = timer_control[TSRU_CTL_T0RUN];
  wire t1Run = timer_control[TSRU_CTL_T1RUN];
  wire t0PreTick = clock_select_control[TSRU_CKS_T0PRE] | preTick12;
  wire t1PreTick = clock_select_control[TSRU_CKS_T1PRE] | preTick12;
  wire t0Tick = timer_mode_select[TSRU_MOD_T0CSEL] ? pinFall[2] : t0PreTick; // [R07] [R02]
  wire t0Enable = t0Run & (~timer_mode_select[TSRU_MOD_T0GATE] | gateActive0); // [R06] [R01]
  wire t0LoAdv = t0Tick & t0Enable;
  wire t0HiAdv = t0Split & t1Run & t0PreTick; // [R03]
  // Timer one loses its pin and gate while timer zero is split; its mode alone runs it
  wire t1Tick = (timer_mode_select[TSRU_MOD_T1CSEL] && !t0Split) ? pinFall[3] : t1PreTick; // [R07] [R04]
  wire t1Gated = t0Split | ~timer_mode_select[TSRU_MOD_T1GATE] | gateActive1; // [R06]
  wire t1Adv = t1Tick & ~t1Off & (t0Split | t1Run) & t1Gated; // [R05]

  wire [16:0] t0Step = tsru_step(t_zero_low_byte, t_zero_high_byte, t0Mode);
  wire [16:0] t1Step = tsru_step(t_one_low_byte, t_one_high_byte, t1Mode);
  wire [8:0] t0LoSplit = {1'b0, t_zero_low_byte} + 9'h001; // [R01]
  wire [8:0] t0HiSplit = {1'b0, t_zero_high_byte} + 9'h001;
  wire t0OvfEvt = t0LoAdv & (t0Split ? t0LoSplit[8] : t0Step[16]);
  wire t0HiOvfEvt = t0HiAdv & t0HiSplit[8];
  wire t1StepOvf = t1Adv & t1Step[16];
  wire t1FlagSet = t0Split ? t0HiOvfEvt : t1StepOvf; // [R03] [R04]

  logic [7:0] next_t0Lo;
  logic [7:0] next_t0Hi;
  always_comb
  begin
    next_t0Lo = t_zero_low_byte;
    next_t0Hi = t_zero_high_byte;
    if (t0Split)
    begin
      if (t0LoAdv)
        next_t0Lo = t0LoSplit[7:0];
      if (t0HiAdv)
        next_t0Hi = t0HiSplit[7:0];
    end
    else if (t0LoAdv)
    begin
      next_t0Lo = t0Step[7:0];
      next_t0Hi = t0Step[15:8];
    end
    if (wrT0Lo)
      next_t0Lo = regWriteData;
    if (wrT0Hi)
      next_t0Hi = regWriteData;
  end

  wire [7:0] next_t1Lo = wrT1Lo ? regWriteData : (t1Adv ? t1Step[7:0] : t_one_low_byte);
  wire [7:0] next_t1Hi = wrT1Hi ? regWriteData : (t1Adv ? t1Step[15:8] : t_one_high_byte);

  // Hardware set beats a software clear in the same cycle
  logic [7:0] next_control;
  always_comb
  begin
    next_control = wrCtl ? {4'h0, regWriteData[3:0]} : timer_control;
    next_control[TSRU_CTL_T0FLAG] = next_control[TSRU_CTL_T0FLAG] | t0OvfEvt;
    next_control[TSRU_CTL_T1FLAG] = next_control[TSRU_CTL_T1FLAG] | t1FlagSet;
  end

  // ****************************************
  // Timer three
  // ****************************************
  wire t_three_split = t_three_control[TSRU_T3C_SPLIT];
  wire t3Capture = t_three_control[TSRU_T3C_CAPEN];
  wire t3Run = t_three_control[TSRU_T3C_RUN];
  wire t3ExtSel = t_three_control[TSRU_T3C_EXTCLK];
  wire t3SlowTick = t3ExtSel ? extTick8 : preTick12; // [R16]
  wire t3LowTick = clock_select_control[TSRU_CKS_T3LOW] | t3SlowTick; // [R11] [R16]
  wire t3HighTick = clock_select_control[TSRU_CKS_T3HIGH] | t3SlowTick;
  // Capture modes are not built; the counter simply holds while capture is enabled
  wire t3Adv16 = ~t_three_split & ~t3Capture & t3Run & t3LowTick; // [R10]
  wire t3LowAdv = t_three_split & ~t3Capture & t3LowTick; // [R15]
  wire t3HighAdv = t_three_split & ~t3Capture & t3Run & t3HighTick; // [R15]
  wire [16:0] t3Sum = {1'b0, t_three_high_byte, t_three_low_byte} + 17'h00001;
  wire t3Wrap16 = t3Adv16 & t3Sum[16];
  wire t3LowWrap = (t3Adv16 | t3LowAdv) & t_three_low_byte == 8'hff;
  wire t3HighWrap = t3Wrap16 | (t3HighAdv & t_three_high_byte == 8'hff);

  logic [7:0] next_t3Lo;
  logic [7:0] next_t3Hi;
  always_comb
  begin
    next_t3Lo = t_three_low_byte;
    next_t3Hi = t_three_high_byte;
    if (t3Wrap16)
    begin
      next_t3Lo = t_three_reload_low; // [R12]
      next_t3Hi = t_three_reload_high;
    end
    else if (t3Adv16)
    begin
      next_t3Lo = t3Sum[7:0];
      next_t3Hi = t3Sum[15:8];
    end
    else
    begin
      if (t3LowAdv)
        next_t3Lo = t3LowWrap ? t_three_reload_low : t_three_low_byte + 8'h01; // [R14]
      if (t3HighAdv)
        next_t3Hi = t3HighWrap ? t_three_reload_high : t_three_high_byte + 8'h01; // [R14]
    end
    if (wrT3Lo)
      next_t3Lo = regWriteData;
    if (wrT3Hi)
      next_t3Hi = regWriteData;
  end

  // Flags are only cleared by software writing zero [R18]
  logic [7:0] next_t3Ctl;
  always_comb
  begin
    next_t3Ctl = wrT3Ctl ? regWriteData : t_three_control;
    next_t3Ctl[TSRU_T3C_HIGHOVF] = next_t3Ctl[TSRU_T3C_HIGHOVF] | t3HighWrap; // [R12] [R17]
    next_t3Ctl[TSRU_T3C_LOWOVF] = next_t3Ctl[TSRU_T3C_LOWOVF] | t3LowWrap; // [R17]
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  wire t3LowIrqEvt = t3LowWrap & t_three_control[TSRU_T3C_LOWIRQ]; // [R13] [R17]
  wire [3:0] irqEvents = {t3LowIrqEvt, t3HighWrap, t1FlagSet, t0OvfEvt}; // [R13]
  wire [3:0] next_irqStatus = (rdStatus ? 4'h0 : irqStatus) | irqEvents;

  // ****************************************
  // Register update
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timer_control <= TSRU_RESET_BYTE;
      timer_mode_select <= TSRU_RESET_BYTE;
      clock_select_control <= TSRU_RESET_BYTE;
      gatePolarity <= 2'h0;
      t_zero_low_byte <= TSRU_RESET_BYTE;
      t_zero_high_byte <= TSRU_RESET_BYTE;
      t_one_low_byte <= TSRU_RESET_BYTE;
      t_one_high_byte <= TSRU_RESET_BYTE;
      t_three_control <= TSRU_RESET_BYTE;
      t_three_low_byte <= TSRU_RESET_BYTE;
      t_three_high_byte <= TSRU_RESET_BYTE;
      t_three_reload_low <= TSRU_RESET_BYTE;
      t_three_reload_high <= TSRU_RESET_BYTE;
      irqStatus <= TSRU_RESET_IRQ;
      irqMask <= TSRU_RESET_IRQ;
    end
    else
    begin
      timer_control <= next_control;
      t_zero_low_byte <= next_t0Lo;
      t_zero_high_byte <= next_t0Hi;
      t_one_low_byte <= next_t1Lo;
      t_one_high_byte <= next_t1Hi;
      t_three_control <= next_t3Ctl;
      t_three_low_byte <= next_t3Lo;
      t_three_high_byte <= next_t3Hi;
      irqStatus <= next_irqStatus;
      if (regWrite && regAddr == TSRU_ADDR_MODE)
        timer_mode_select <= regWriteData;
      if (regWrite && regAddr == TSRU_ADDR_CLKSEL)
        clock_select_control <= {4'h0, regWriteData[3:0]};
      if (regWrite && regAddr == TSRU_ADDR_GATEPOL)
        gatePolarity <= regWriteData[1:0];
      if (regWrite && regAddr == TSRU_ADDR_T3RLLO)
        t_three_reload_low <= regWriteData;
      if (regWrite && regAddr == TSRU_ADDR_T3RLHI)
        t_three_reload_high <= regWriteData;
      if (regWrite && regAddr == TSRU_ADDR_IRQMASK)
        irqMask <= regWriteData[3:0];
    end
  end

  // ****************************************
  // Read data and outputs
  // ****************************************
  logic [7:0] readMux;
  always_comb
  begin
    case (regAddr)
      TSRU_ADDR_CONTROL: readMux = timer_control;
      TSRU_ADDR_MODE: readMux = timer_mode_select;
      TSRU_ADDR_CLKSEL: readMux = clock_select_control;
      TSRU_ADDR_GATEPOL: readMux = {6'h00, gatePolarity};
      TSRU_ADDR_T0LO: readMux = t_zero_low_byte;
      TSRU_ADDR_T0HI: readMux = t_zero_high_byte;
      TSRU_ADDR_T1LO: readMux = t_one_low_byte;
      TSRU_ADDR_T1HI: readMux = t_one_high_byte;
      TSRU_ADDR_T3CTRL: readMux = t_three_control;
      TSRU_ADDR_T3LO: readMux = t_three_low_byte;
      TSRU_ADDR_T3HI: readMux = t_three_high_byte;
      TSRU_ADDR_T3RLLO: readMux = t_three_reload_low;
      TSRU_ADDR_T3RLHI: readMux = t_three_reload_high;
      TSRU_ADDR_IRQSTAT: readMux = {4'h0, irqStatus};
      TSRU_ADDR_IRQMASK: readMux = {4'h0, irqMask};
      default: readMux = 8'h00;
    endcase
  end

  // Interrupt follows status one cycle late, keeping the output straight from a flop
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regReadData <= 8'h00;
      irq <= 1'b0;
      t1OverflowTick <= 1'b0;
    end
    else
    begin
      regReadData <= regRead ? readMux : 8'h00;
      irq <= |(irqStatus & irqMask);
      t1OverflowTick <= t1StepOvf; // [R04]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_split_low_ovf: assert property (t0Split && t0LoAdv && t_zero_low_byte == 8'hff && !wrCtl && !wrT0Lo // [R01]
    |=> timer_control[TSRU_CTL_T0FLAG] && t_zero_low_byte == 8'h00) else $error("split low byte overflow missed");
  chk_split_high_ovf: assert property (t0Split && t0HiAdv && t_zero_high_byte == 8'hff && !wrCtl // [R03]
    |=> timer_control[TSRU_CTL_T1FLAG]) else $error("split high byte did not set timer one flag");
  chk_t1_quiet_split: assert property (t0Split && t1StepOvf && !t0HiOvfEvt && !timer_control[TSRU_CTL_T1FLAG] // [R04]
    && !wrCtl |=> !timer_control[TSRU_CTL_T1FLAG] && t1OverflowTick) else $error("timer one flagged in split");
  chk_t1_mode3_stop: assert property (t0Split && t1Off && !wrT1Lo && !wrT1Hi // [R05]
    |=> $stable({t_one_high_byte, t_one_low_byte})) else $error("timer one counted in mode 3");
  chk_gate_blocks: assert property (timer_mode_select[TSRU_MOD_T0GATE] && !gateActive0 && !wrT0Lo // [R06]
    |=> $stable(t_zero_low_byte)) else $error("gated timer zero counted");
  chk_sys_div_12: assert property (preTick12 |=> (!preTick12) [*8] ##1 !preTick12 ##1 !preTick12 // [R11]
    ##1 !preTick12 ##1 preTick12) else $error("divide by 12 spacing wrong");
  chk_t3_reload_16: assert property (t3Wrap16 && !wrT3Lo && !wrT3Hi && !wrT3Ctl // [R12]
    |=> {t_three_high_byte, t_three_low_byte} == $past({t_three_reload_high, t_three_reload_low})
    && t_three_control[TSRU_T3C_HIGHOVF]) else $error("16-bit reload missed");
  chk_t3_low_irq: assert property (t3LowWrap && t_three_control[TSRU_T3C_LOWIRQ] && irqMask[TSRU_IRQ_T3LOW] // [R13]
    |-> ##2 irq) else $error("low wrap interrupt missed");
  chk_t3_split_low: assert property (t3LowAdv && t_three_low_byte == 8'hff && !wrT3Lo && !wrT3Ctl // [R14]
    |=> t_three_low_byte == $past(t_three_reload_low) && t_three_control[TSRU_T3C_LOWOVF])
    else $error("split low reload missed");
  chk_t3_split_run: assert property (t_three_split && !t3Run && !wrT3Hi |=> $stable(t_three_high_byte)) // [R15]
    else $error("split high byte ran while stopped");

  cov_split_both: cover property (t0OvfEvt && t0Split ##[1:300] t0HiOvfEvt);
  cov_t3_split_high: cover property (t3HighAdv && t3HighWrap);
  cov_t3_16_wrap: cover property (t3Wrap16);
  cov_irq_rise: cover property ($rose(irq));

endmodule // tsru_timer_unit

// *** verification/tsru_pin_model.sv ***
// Model of the pins outside the unit: count pins, gate levels, external oscillator.
// Assumes the bench calls its tasks; some pin changes land on clk_sys rising edges.
`timescale 1ns/10ps

module tsru_pin_model
(
  input wire logic clk_sys,
  output logic count_pin_zero,
  output logic count_pin_one,
  output logic ext_gate_in_zero,
  output logic ext_gate_in_one,
  output logic extClockIn
);
  // Count pins idle high; the oscillator stands low outside bursts
  initial
  begin
    count_pin_zero = 1'b1;
    count_pin_one = 1'b1;
    ext_gate_in_zero = 1'b0;
    ext_gate_in_one = 1'b0;
    extClockIn = 1'b0;
  end

  // Levels held several cycles so the synchronisers see each one
  task automatic fall_pulses(input int n);
    repeat (n)
    begin
      #13 count_pin_zero = 1'b0;
      count_pin_one = 1'b0;
      #27 count_pin_zero = 1'b1;
      count_pin_one = 1'b1;
      #27;
    end
  endtask

  task automatic set_gate(input logic level);
    ext_gate_in_zero = level;
    ext_gate_in_one = level;
  endtask

  // Well below clk_sys / 6
  task automatic ext_edges(input int n);
    repeat (n)
    begin
      #15 extClockIn = 1'b1;
      #15 extClockIn = 1'b0;
    end
  endtask
endmodule // tsru_pin_model

// *** verification/timer_split_and_reload_unit_test.sv ***
// Self-checking bench for the timer split and reload unit.
// Assumes tsru_pkg, the unit and the pin model are compiled first.
`timescale 1ns/10ps

module timer_split_and_reload_unit_test;
  import tsru_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWriteData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic rdSeen = 1'b0;
  logic [7:0] regReadData;
  logic count_pin_zero, count_pin_one, ext_gate_in_zero, ext_gate_in_one, extClockIn, irq, t1OverflowTick;
  logic [7:0] expQ[$];
  logic [15:0] seed = 16'h9806;
  int fails = 0;
  int checked = 0;
  int ticks;
  int cyc = 0;

  always #2 clk_sys = ~clk_sys;

  tsru_timer_unit i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .count_pin_zero(count_pin_zero),
    .count_pin_one(count_pin_one), .ext_gate_in_zero(ext_gate_in_zero), .ext_gate_in_one(ext_gate_in_one),
    .extClockIn(extClockIn), .irq(irq), .t1OverflowTick(t1OverflowTick));

  tsru_pin_model i_pins (.clk_sys(clk_sys), .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
    .ext_gate_in_zero(ext_gate_in_zero), .ext_gate_in_one(ext_gate_in_one), .extClockIn(extClockIn));

  // ****************************************
  // Shared tasks
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  // The expectation is queued here and compared by the watcher
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    expQ.push_back(exp);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic count_ticks(input int n);
    ticks = 0;
    repeat (n)
    begin
      @(posedge clk_sys);
      if (t1OverflowTick === 1'b1)
        ticks++;
    end
  endtask

  // ****************************************
  // Watcher: read data stands only in the cycle after the strobe
  // ****************************************
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 50000)
    begin
      fails++;
      close_out();
    end
    if (rdSeen)
    begin
      if (expQ.size() > 0)
        check("read data", regReadData, expQ.pop_front());
      else
        fails++;
    end
    rdSeen <= regRead;
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    wr(4'hf, 8'hff);
    for (int a = 0; a < 16; a++)
      rd(4'(a), 8'h00);
    repeat (4)
    begin
      seed = lfsr(seed);
      wr(TSRU_ADDR_MODE, seed[7:0]);
      rd(TSRU_ADDR_MODE, seed[7:0]);
    end
    wr(TSRU_ADDR_MODE, 8'h00);
    // Timer three as one 16-bit value, wrapping two ticks after start
    wr(TSRU_ADDR_CLKSEL, 8'h04);
    wr(TSRU_ADDR_T3LO, 8'hfe);
    wr(TSRU_ADDR_T3HI, 8'hff);
    wr(TSRU_ADDR_T3RLLO, 8'h00);
    wr(TSRU_ADDR_T3RLHI, seed[15:8]);
    wr(TSRU_ADDR_IRQMASK, 8'h04);
    wr(TSRU_ADDR_T3CTRL, 8'h04);
    cycles(8);
    check("irq 16-bit", {7'h00, irq}, 8'h01);
    rd(TSRU_ADDR_T3CTRL, 8'hc4);
    rd(TSRU_ADDR_T3HI, seed[15:8]);
    rd(TSRU_ADDR_IRQSTAT, 8'h04);
    wr(TSRU_ADDR_T3CTRL, 8'h00);
    rd(TSRU_ADDR_T3CTRL, 8'h00);
    check("irq cleared", {7'h00, irq}, 8'h00);
    // Timer zero split, low byte counting pin falls behind its gate
    wr(TSRU_ADDR_MODE, 8'h0f);
    wr(TSRU_ADDR_CLKSEL, 8'h0f);
    wr(TSRU_ADDR_GATEPOL, 8'h01);
    wr(TSRU_ADDR_T0LO, 8'hfe);
    wr(TSRU_ADDR_T0HI, 8'hfe);
    wr(TSRU_ADDR_CONTROL, 8'h03);
    i_pins.fall_pulses(2);
    cycles(8);
    rd(TSRU_ADDR_T0LO, 8'hfe);
    i_pins.set_gate(1'b1);
    i_pins.fall_pulses(2);
    cycles(8);
    rd(TSRU_ADDR_T0LO, 8'h00);
    rd(TSRU_ADDR_CONTROL, 8'h0f);
    rd(TSRU_ADDR_IRQSTAT, 8'h03);
    wr(TSRU_ADDR_MODE, 8'h2f);
    count_ticks(600);
    check("ticks mode 2", 8'(ticks >= 2), 8'h01);
    wr(TSRU_ADDR_MODE, 8'h3f);
    cycles(8);
    count_ticks(600);
    check("ticks mode 3", 8'(ticks), 8'h00);
    wr(TSRU_ADDR_CONTROL, 8'h00);
    // Second clear, so no high-byte set in the first write's cycle survives
    wr(TSRU_ADDR_CONTROL, 8'h00);
    wr(TSRU_ADDR_MODE, 8'h2f);
    count_ticks(300);
    check("ticks flag clear", 8'(ticks >= 1), 8'h01);
    rd(TSRU_ADDR_CONTROL, 8'h00);
    wr(TSRU_ADDR_MODE, 8'h00);
    i_pins.set_gate(1'b0);
    rd(TSRU_ADDR_IRQSTAT, 8'h02);
    // Timer three split, low half on the external clock divided by 8
    wr(TSRU_ADDR_CLKSEL, 8'h00);
    wr(TSRU_ADDR_T3LO, 8'hff);
    wr(TSRU_ADDR_T3HI, 8'h55);
    wr(TSRU_ADDR_T3RLLO, 8'h3c);
    wr(TSRU_ADDR_IRQMASK, 8'h08);
    wr(TSRU_ADDR_T3CTRL, 8'h29);
    i_pins.ext_edges(8);
    cycles(16);
    check("irq split", {7'h00, irq}, 8'h01);
    rd(TSRU_ADDR_T3LO, 8'h3c);
    rd(TSRU_ADDR_T3HI, 8'h55);
    rd(TSRU_ADDR_T3CTRL, 8'h69);
    rd(TSRU_ADDR_IRQSTAT, 8'h08);
    wr(TSRU_ADDR_T3CTRL, 8'h29);
    rd(TSRU_ADDR_T3CTRL, 8'h29);
    // High half running on the system clock, wrapping to its own reload
    wr(TSRU_ADDR_CLKSEL, 8'h08);
    wr(TSRU_ADDR_T3RLHI, 8'hf0);
    wr(TSRU_ADDR_T3HI, 8'hfe);
    wr(TSRU_ADDR_T3CTRL, 8'h2c);
    cycles(4);
    rd(TSRU_ADDR_T3CTRL, 8'hac);
    rd(TSRU_ADDR_IRQSTAT, 8'h04);
    cycles(4);
    close_out();
  end
endmodule // timer_split_and_reload_unit_test
